// ===== iprc_pkg.sv
package iprc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned NUM_REGS = 5;
  localparam int unsigned NUM_SRC = 16;
  localparam logic [3:0] ADDR_MSB_LSB = 4'h0;
  localparam logic [7:0] OFF_REG0 = 8'h00;
  localparam logic [7:0] OFF_REG1 = 8'h04;
  localparam logic [7:0] OFF_REG2 = 8'h08;
  localparam logic [7:0] OFF_REG3 = 8'h0c;
  localparam logic [7:0] OFF_REG4 = 8'h10;

  // Implemented bits per register; everything else is unimplemented
  localparam logic [15:0] MASK_REG0 = 16'h7777;
  localparam logic [15:0] MASK_REG1 = 16'h0077;
  localparam logic [15:0] MASK_REG2 = 16'h7777;
  localparam logic [15:0] MASK_REG3 = 16'h7707;
  localparam logic [15:0] MASK_REG4 = 16'h7770;

  // Each field resets to 100
  localparam logic [15:0] RST_REG0 = 16'h4444;
  localparam logic [15:0] RST_REG1 = 16'h0044;
  localparam logic [15:0] RST_REG2 = 16'h4444;
  localparam logic [15:0] RST_REG3 = 16'h4404;
  localparam logic [15:0] RST_REG4 = 16'h4440;

  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [2:0] LEVEL_MAX = 3'h7;
  localparam logic [2:0] LEVEL_RST = 3'h4;

  typedef logic [2:0] iprc_level_t;

  // Levels handed to the arbitration logic
  typedef struct packed {
    iprc_level_t uart1_receive_priority;
    iprc_level_t spi1_event_priority;
    iprc_level_t spi1_fault_priority;
    iprc_level_t timer3_priority;
    iprc_level_t adc_done_priority;
    iprc_level_t uart1_transmit_priority;
    iprc_level_t change_notify_priority;
    iprc_level_t comparator_priority;
    iprc_level_t i2c1_master_priority;
    iprc_level_t i2c1_slave_priority;
    iprc_level_t capture8_priority;
    iprc_level_t capture7_priority;
    iprc_level_t ext_irq1_priority;
    iprc_level_t timer4_priority;
    iprc_level_t compare4_priority;
    iprc_level_t compare3_priority;
  } iprc_levels_s;

  // Bus states
  typedef enum logic [1:0] {
    IPRC_IDLE = 2'b01,
    IPRC_ACK = 2'b10
  } iprc_state_e;

endpackage

// ===== iprc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module iprc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output var iprc_pkg::iprc_levels_s levels_o,
  output logic [15:0] src_enabled_o
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] regs [iprc_pkg::NUM_REGS];
  logic [15:0] mask_tab [iprc_pkg::NUM_REGS];
  logic [15:0] rst_tab [iprc_pkg::NUM_REGS];
  iprc_pkg::iprc_state_e state;
  logic req;
  logic hit;
  logic [2:0] idx;
  logic [15:0] byte_mask;

  assign mask_tab[0] = iprc_pkg::MASK_REG0;
  assign mask_tab[1] = iprc_pkg::MASK_REG1;
  assign mask_tab[2] = iprc_pkg::MASK_REG2;
  assign mask_tab[3] = iprc_pkg::MASK_REG3;
  assign mask_tab[4] = iprc_pkg::MASK_REG4;
  assign rst_tab[0] = iprc_pkg::RST_REG0;
  assign rst_tab[1] = iprc_pkg::RST_REG1;
  assign rst_tab[2] = iprc_pkg::RST_REG2;
  assign rst_tab[3] = iprc_pkg::RST_REG3;
  assign rst_tab[4] = iprc_pkg::RST_REG4;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Each register takes one aligned word; low address bits are ignored
  assign idx = adr_i[4:2];
  assign hit = (adr_i[7:5] == 3'h0) && (idx < 3'(iprc_pkg::NUM_REGS));
  assign req = cyc_i && stb_i && (state == iprc_pkg::IPRC_IDLE);
  assign byte_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  // Single-cycle ack; no request is taken in the ack cycle, so one held until ack is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= iprc_pkg::IPRC_IDLE;
    end else begin
      case (state)
        iprc_pkg::IPRC_IDLE: begin
          if (req) begin
            state <= iprc_pkg::IPRC_ACK;
          end
        end
        iprc_pkg::IPRC_ACK: begin
          state <= iprc_pkg::IPRC_IDLE;
        end
        default: begin
          state <= iprc_pkg::IPRC_IDLE;
        end
      endcase
    end
  end

  assign ack_o = (state == iprc_pkg::IPRC_ACK);

  // ----------------------------------------
  // Register write, one per entry
  // ----------------------------------------
  for (genvar g = 0; g < iprc_pkg::NUM_REGS; g++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs[g] <= rst_tab[g];
      end else if (req && we_i && hit && (idx == 3'(g))) begin
        // Unimplemented bits stay zero whatever is written
        regs[g] <= (regs[g] & ~byte_mask) | (dat_i[15:0] & byte_mask & mask_tab[g]);
      end
    end
  end

  // Read data is registered with the ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req && !we_i && hit) begin
      dat_o <= {16'h0, regs[idx] & mask_tab[idx]};
    end else if (req) begin
      dat_o <= 32'h0;
    end
  end

  // ----------------------------------------
  // Level outputs
  // ----------------------------------------
  // Straight from the flops, so a write shows on the next cycle with no extra stage
  assign levels_o.uart1_receive_priority = regs[0][14:12];
  assign levels_o.spi1_event_priority = regs[0][10:8];
  assign levels_o.spi1_fault_priority = regs[0][6:4];
  assign levels_o.timer3_priority = regs[0][2:0];
  assign levels_o.adc_done_priority = regs[1][6:4];
  assign levels_o.uart1_transmit_priority = regs[1][2:0];
  assign levels_o.change_notify_priority = regs[2][14:12];
  assign levels_o.comparator_priority = regs[2][10:8];
  assign levels_o.i2c1_master_priority = regs[2][6:4];
  assign levels_o.i2c1_slave_priority = regs[2][2:0];
  assign levels_o.capture8_priority = regs[3][14:12];
  assign levels_o.capture7_priority = regs[3][10:8];
  assign levels_o.ext_irq1_priority = regs[3][2:0];
  assign levels_o.timer4_priority = regs[4][14:12];
  assign levels_o.compare4_priority = regs[4][10:8];
  assign levels_o.compare3_priority = regs[4][6:4];

  // Level 000 masks the source off; 001..111 are live levels 1..7
  for (genvar s = 0; s < iprc_pkg::NUM_SRC; s++) begin : g_en
    assign src_enabled_o[s] = (levels_o[3*s +: 3] != iprc_pkg::LEVEL_OFF);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");
  chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o) else $error("request not acked next cycle");
  chk_reset_level: assert property (@(posedge clk_i)
    $past(rst_i) |-> levels_o.timer3_priority == iprc_pkg::LEVEL_RST)
    else $error("reset level not 100");
  chk_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (regs[1] & ~iprc_pkg::MASK_REG1) == 16'h0)
    else $error("unimplemented bits set");
  chk_write_applies: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == iprc_pkg::OFF_REG0 && sel_i[0]) |=>
    levels_o.timer3_priority == $past(dat_i[2:0]))
    else $error("timer3 write not applied next cycle");
  chk_adc_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == iprc_pkg::OFF_REG1 && sel_i[0]) |=>
    levels_o.adc_done_priority == $past(dat_i[6:4]))
    else $error("adc field misplaced");
  chk_disable_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (levels_o.capture8_priority == iprc_pkg::LEVEL_OFF) |-> !src_enabled_o[5])
    else $error("level zero source still enabled");
  chk_max_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    (levels_o.compare3_priority == iprc_pkg::LEVEL_MAX) |-> src_enabled_o[0])
    else $error("level seven source not enabled");
  chk_reg3_hole: assert property (@(posedge clk_i) disable iff (rst_i)
    regs[3][7:3] == 5'h0 && regs[2][15] == 1'b0)
    else $error("hole bits nonzero");
  chk_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == iprc_pkg::OFF_REG4) |=>
    dat_o[3:0] == 4'h0 && dat_o[31:16] == 16'h0)
    else $error("reg4 read shows unimplemented bits");

  cov_write: cover property (@(posedge clk_i) req && we_i && hit);
  cov_read: cover property (@(posedge clk_i) req && !we_i && hit);
  cov_unmapped: cover property (@(posedge clk_i) req && !hit);
  cov_disabled: cover property (@(posedge clk_i) src_enabled_o != 16'hffff);

endmodule
`default_nettype wire

// ===== iprc_arb_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Stand-in for the arbitration logic
// ----------------------------------------
module iprc_arb_model (
  input wire iprc_pkg::iprc_levels_s levels_i,
  input wire logic [15:0] req_i,
  output logic [2:0] win_level_o
);
  logic [47:0] flat;
  assign flat = levels_i;
  // Level zero can never beat the idle result, so a disabled source never wins
  always_comb begin
    win_level_o = 3'h0;
    for (int s = 0; s < 16; s++) begin
      if (req_i[s] && flat[3*s+:3] > win_level_o) begin
        win_level_o = flat[3*s+:3];
      end
    end
  end
endmodule
`default_nettype wire

// ===== irq_priority_regs_2_to_6_test.sv
`timescale 1ns/1ps
`default_nettype none
module irq_priority_regs_2_to_6_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  iprc_pkg::iprc_levels_s levels_o;
  logic [15:0] src_enabled_o;
  logic [15:0] req = 16'h0;
  logic [2:0] win;
  logic [31:0] q;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [15:0] rsts [5] = '{16'h4444, 16'h0044, 16'h4444, 16'h4404, 16'h4440};
  logic [15:0] masks [5] = '{16'h7777, 16'h0077, 16'h7777, 16'h7707, 16'h7770};

  iprc_regs i_iprc_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .levels_o(levels_o), .src_enabled_o(src_enabled_o));
  iprc_arb_model i_iprc_arb_model (.levels_i(levels_o), .req_i(req), .win_level_o(win));

  initial forever #12.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled, then releases for at least one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h3;
    dat_i <= {16'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(levels_o, {16{3'h4}});
    for (int r = 0; r < 5; r++) begin
      wb(1'b0, offs[r], 16'h0);
      chk(q, {16'h0, rsts[r]});
    end
    $display("test reset values done");
    for (int r = 0; r < 5; r++) begin
      wb(1'b1, offs[r], 16'hffff);
      wb(1'b0, offs[r], 16'h0);
      chk(q, {16'h0, masks[r]});
    end
    #1 chk(levels_o, {16{3'h7}});
    wb(1'b0, 8'h14, 16'h0);
    chk(q, 48'h0);
    $display("test all ones done");
    wb(1'b1, 8'h00, 16'h7130);
    #1 chk(src_enabled_o, 16'hefff);
    req <= 16'h1000;
    #1 chk(win, 3'h0);
    req <= 16'h4000;
    #1 chk(win, 3'h1);
    req <= 16'h7000;
    #1 chk(win, 3'h3);
    req <= 16'hffff;
    #1 chk(win, 3'h7);
    $display("test levels done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 16'h0);
    chk(q, 48'h4444);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
